// file: common/irq_pkg.sv
package irq_pkg;
  // register addresses on the core's special-function bus
  localparam logic [7:0]  SFR_EN_LOW     = 8'hA8;
  localparam logic [7:0]  SFR_PRIO_LOW   = 8'hB8;
  localparam logic [7:0]  SFR_EN_HIGH    = 8'hE8;
  localparam logic [7:0]  SFR_PRIO_HIGH  = 8'hF8;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  // writable bits; reserved bits read back zero
  localparam logic [7:0]  EN_HIGH_MASK   = 8'hFC;
  localparam logic [7:0]  PRIO_LOW_MASK  = 8'h7F;
  localparam logic [7:0]  PRIO_HIGH_MASK = 8'hFD;
  localparam int          GATE_BIT       = 7;
  // bit positions in the high enable and high priority registers
  localparam int          HB_PAD         = 7;
  localparam int          HB_USB         = 6;
  localparam int          HB_COMB        = 5;
  localparam int          HB_I2C         = 4;
  localparam int          HB_CZERO       = 3;
  localparam int          HB_CONE        = 2;
  localparam int          HB_NUM7        = 0;
  // interrupt numbers, also the fixed conflict rank
  localparam int          NUM_SRC        = 15;
  localparam int          N_EXT_ZERO     = 0;
  localparam int          N_T0           = 1;
  localparam int          N_EXT_ONE      = 2;
  localparam int          N_T1           = 3;
  localparam int          N_DBG          = 4;
  localparam int          N_T2           = 5;
  localparam int          N_WIRED        = 6;
  localparam int          N_RSV7         = 7;
  localparam int          N_RSV8         = 8;
  localparam int          N_CONE         = 9;
  localparam int          N_CZERO        = 10;
  localparam int          N_I2C          = 11;
  localparam int          N_COMB         = 12;
  localparam int          N_USB          = 13;
  localparam int          N_PAD          = 14;
  // vector address = base + number * 8
  localparam logic [15:0] VEC_BASE       = 16'h0003;
  localparam int          VEC_SHIFT      = 3;
  // synchronised pins: ext zero, ext one, pads a..d
  localparam int          SYNC_W         = 6;
  localparam int          PADS           = 4;
endpackage

// file: rtl/interrupt_enable_priority.sv
// Functional notes
// (RULE1) each source has its own enable bit
// (RULE2) low enable bit 7 gates all interrupts
// (RULE3) low enable bits 6..4: wired, timer3, debug
// (RULE4) low enable bits 3..0: second_timer, pin1, first timer, pin0
// (RULE5) pin one polarity invertible, enable bit 2
// (RULE6) high enable bit 7: pad interrupt, per-pad gating
// (RULE7) high bit 6 usb, bit 5 combined fifo/serial
// (RULE8) high bits 4..2: i2c, contactless zero, one
// (RULE9) software writes zero to high bits 1..0
// (RULE10) each source high or low priority
// (RULE11) high priority request served first
// (RULE12) same level: better fixed rank wins
// (RULE13) rank follows number, zero highest
// (RULE14) vector is 0003h plus number times eight
// (RULE15) high request preempts low handler
// (RULE16) one instruction runs after return first
// (RULE17) low priority bit 7 reserved, 6..4 sources
// (RULE18) low priority bits 3..0 sources
// (RULE19) high priority bits 7..2 sources
// (RULE20) needs enable and gate, no equal preempt
// (RULE21) all registers reset to zero
`timescale 1ns/1ps
module interrupt_enable_priority
  import irq_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [7:0]  sfrAddr,
  input  wire logic        sfrWrEn,
  input  wire logic [7:0]  sfrWrData,
  input  wire logic        sfrRdEn,
  output logic      [7:0]  sfrRdData_r,
  input  wire logic        extPinIrqZero,
  input  wire logic        extPinIrqOne,
  input  wire logic        extOneInvert,
  input  wire logic        firstTimerIrq,
  input  wire logic        secondTimerIrq,
  input  wire logic        thirdTimerIrq,
  input  wire logic        debugSerialIrq,
  input  wire logic        wiredSecureIrq,
  input  wire logic        contactlessReqZero,
  input  wire logic        contactlessReqOne,
  input  wire logic        i2cIrq,
  input  wire logic        fifoIrq,
  input  wire logic        spiIrq,
  input  wire logic        fastSerialIrq,
  input  wire logic        usbIrq,
  input  wire logic [3:0]  padIrqPins,
  input  wire logic [3:0]  padEnable,
  input  wire logic [3:0]  padLevel,
  input  wire logic        irqAck,
  input  wire logic        returnFromIrq,
  input  wire logic        instrDone,
  output logic             irqReq_r,
  output logic             irqHigh_r,
  output logic      [3:0]  irqNumber_r,
  output logic      [15:0] irqVector_r
);

  logic [7:0]         enLow_r;
  logic [7:0]         enHigh_r;
  logic [7:0]         prioLow_r;
  logic [7:0]         prioHigh_r;
  logic               hiActive_r;
  logic               loActive_r;
  logic               holdOff_r;
  logic [SYNC_W-1:0]  pinRaw;
  logic [SYNC_W-1:0]  pinSyncd;
  logic               extOneLevel;
  logic               padHit;
  logic [NUM_SRC-1:0] srcVec;
  logic [NUM_SRC-1:0] enVec;
  logic [NUM_SRC-1:0] prioVec;
  logic [NUM_SRC-1:0] cand;
  logic [4:0]         hiPick;
  logic [4:0]         loPick;
  logic               hiFound;
  logic               loFound;
  logic               takeHigh;
  logic               takeLow;
  logic               blockReq;
  logic               irqReq_nxt;
  logic [3:0]         irqNumber_nxt;
  logic [7:0]         rdMux;

  // lowest set index wins
  function automatic logic [4:0] pickFirst(input logic [NUM_SRC-1:0] v);
    logic [4:0] r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] vecOf(input logic [3:0] n);
    return 16'(VEC_BASE + (16'(n) << VEC_SHIFT));
  endfunction

  // only true pins are synchronised; peripherals share mclk
  assign pinRaw = {padIrqPins, extPinIrqOne, extPinIrqZero};

  pin_sync #(
    .W      (SYNC_W)
  ) u_pin_sync (
    .mclk   (mclk),
    .rstn   (rstn),
    .pinIn  (pinRaw),
    .pinOut (pinSyncd)
  );

  assign extOneLevel = pinSyncd[1] ^ extOneInvert;  // see RULE5
  // pad contributes when enabled and at its selected level
  assign padHit = |(padEnable & ~(pinSyncd[5:2] ^ padLevel));  // see RULE6

  always_comb begin
    srcVec = '0;
    srcVec[N_EXT_ZERO] = pinSyncd[0];
    srcVec[N_T0]       = firstTimerIrq;
    srcVec[N_EXT_ONE]  = extOneLevel;
    srcVec[N_T1]       = secondTimerIrq;
    srcVec[N_DBG]      = debugSerialIrq;
    srcVec[N_T2]       = thirdTimerIrq;
    srcVec[N_WIRED]    = wiredSecureIrq;
    srcVec[N_CONE]     = contactlessReqOne;
    srcVec[N_CZERO]    = contactlessReqZero;
    srcVec[N_I2C]      = i2cIrq;
    srcVec[N_COMB]     = fifoIrq | spiIrq | fastSerialIrq;  // see RULE7
    srcVec[N_USB]      = usbIrq;
    srcVec[N_PAD]      = padHit;
  end

  // numbers 7 and 8 have no enable, so never request
  always_comb begin
    enVec = '0;
    enVec[N_WIRED:N_EXT_ZERO] = enLow_r[6:0];  // see RULE1, see RULE3, see RULE4
    enVec[N_CONE]  = enHigh_r[HB_CONE];        // see RULE8
    enVec[N_CZERO] = enHigh_r[HB_CZERO];       // see RULE8
    enVec[N_I2C]   = enHigh_r[HB_I2C];         // see RULE8
    enVec[N_COMB]  = enHigh_r[HB_COMB];        // see RULE7
    enVec[N_USB]   = enHigh_r[HB_USB];         // see RULE7
    enVec[N_PAD]   = enHigh_r[HB_PAD];         // see RULE6
  end

  always_comb begin
    prioVec = '0;
    prioVec[N_WIRED:N_EXT_ZERO] = prioLow_r[6:0];  // see RULE10, see RULE17, see RULE18
    prioVec[N_RSV7]  = prioHigh_r[HB_NUM7];
    prioVec[N_CONE]  = prioHigh_r[HB_CONE];        // see RULE19
    prioVec[N_CZERO] = prioHigh_r[HB_CZERO];       // see RULE19
    prioVec[N_I2C]   = prioHigh_r[HB_I2C];         // see RULE19
    prioVec[N_COMB]  = prioHigh_r[HB_COMB];        // see RULE19
    prioVec[N_USB]   = prioHigh_r[HB_USB];         // see RULE19
    prioVec[N_PAD]   = prioHigh_r[HB_PAD];         // see RULE19
  end

  // enable registers; reserved bits never store
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      enLow_r  <= REG_RESET;  // see RULE21
      enHigh_r <= REG_RESET;  // see RULE21
    end else if (sfrWrEn) begin
      if (sfrAddr == SFR_EN_LOW) begin
        enLow_r <= sfrWrData;
      end
      if (sfrAddr == SFR_EN_HIGH) begin
        enHigh_r <= sfrWrData & EN_HIGH_MASK;  // see RULE9
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prioLow_r  <= REG_RESET;  // see RULE21
      prioHigh_r <= REG_RESET;  // see RULE21
    end else if (sfrWrEn) begin
      if (sfrAddr == SFR_PRIO_LOW) begin
        prioLow_r <= sfrWrData & PRIO_LOW_MASK;  // see RULE17
      end
      if (sfrAddr == SFR_PRIO_HIGH) begin
        prioHigh_r <= sfrWrData & PRIO_HIGH_MASK;
      end
    end
  end

  always_comb begin
    case (sfrAddr)
      SFR_EN_LOW:    rdMux = enLow_r;
      SFR_EN_HIGH:   rdMux = enHigh_r;
      SFR_PRIO_LOW:  rdMux = prioLow_r;
      SFR_PRIO_HIGH: rdMux = prioHigh_r;
      default:       rdMux = 8'h00;
    endcase
  end

  // read data one cycle after the strobe, held until the next read
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sfrRdData_r <= REG_RESET;
    end else if (sfrRdEn) begin
      sfrRdData_r <= rdMux;
    end
  end

  assign cand    = srcVec & enVec & {NUM_SRC{enLow_r[GATE_BIT]}};  // see RULE2, see RULE20
  assign hiPick  = pickFirst(cand & prioVec);   // see RULE12, see RULE13
  assign loPick  = pickFirst(cand & ~prioVec);  // see RULE12, see RULE13
  assign hiFound = hiPick[4];
  assign loFound = loPick[4];

  // a running high handler blocks all; a low one only admits high
  assign takeHigh = hiFound && !hiActive_r;                              // see RULE11, see RULE15
  assign takeLow  = loFound && !hiFound && !hiActive_r && !loActive_r;  // see RULE20
  // request drops on ack so the core never sees a stale grant
  assign blockReq = holdOff_r || irqAck || returnFromIrq;  // see RULE16

  assign irqReq_nxt    = (takeHigh || takeLow) && !blockReq;
  assign irqNumber_nxt = takeHigh ? hiPick[3:0] : loPick[3:0];

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irqReq_r    <= 1'b0;
      irqHigh_r   <= 1'b0;
      irqNumber_r <= 4'h0;
      irqVector_r <= 16'h0000;
    end else begin
      irqReq_r    <= irqReq_nxt;
      irqHigh_r   <= takeHigh;
      irqNumber_r <= irqNumber_nxt;
      irqVector_r <= vecOf(irqNumber_nxt);  // see RULE14
    end
  end

  // in-service levels: return clears the highest, ack sets and wins
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hiActive_r <= 1'b0;
      loActive_r <= 1'b0;
    end else begin
      if (irqAck && irqReq_r && irqHigh_r) begin
        hiActive_r <= 1'b1;  // see RULE15
      end else if (returnFromIrq && hiActive_r) begin
        hiActive_r <= 1'b0;
      end
      if (irqAck && irqReq_r && !irqHigh_r) begin
        loActive_r <= 1'b1;
      end else if (returnFromIrq && !hiActive_r) begin
        loActive_r <= 1'b0;
      end
    end
  end

  // hold off until the instruction after the return completes
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      holdOff_r <= 1'b0;
    end else if (returnFromIrq) begin
      holdOff_r <= 1'b1;  // see RULE16
    end else if (instrDone) begin
      holdOff_r <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  gate_off_a: assert property ( // see RULE2
    !enLow_r[GATE_BIT] |=> !irqReq_r)
    else $error("request raised with global gate clear");

  reset_clear_a: assert property ( // see RULE21
    $past(!rstn) |-> (enLow_r == 8'h00 && enHigh_r == 8'h00
      && prioLow_r == 8'h00 && prioHigh_r == 8'h00 && !irqReq_r))
    else $error("registers not zero after reset");

  vector_map_a: assert property ( // see RULE14
    irqReq_r |-> (irqVector_r[2:0] == 3'h3 && irqVector_r[6:3] == irqNumber_r
      && irqVector_r[15:7] == 9'h000))
    else $error("vector does not match number");

  high_block_a: assert property ( // see RULE20
    hiActive_r |=> !irqReq_r)
    else $error("request during high handler");

  low_preempt_a: assert property ( // see RULE15
    loActive_r |=> (!irqReq_r || irqHigh_r))
    else $error("low request preempted low handler");

  return_from_irq_hold_a: assert property ( // see RULE16
    returnFromIrq |=> !irqReq_r [*2])
    else $error("interrupt taken right after return");

  high_first_a: assert property ( // see RULE11
    irqReq_r && $past(hiFound) |-> irqHigh_r)
    else $error("low request chosen over high");

  ack_level_a: assert property ( // see RULE15
    irqAck && irqReq_r && irqHigh_r |=> hiActive_r && !irqReq_r)
    else $error("high ack not recorded");

  enable_need_a: assert property ( // see RULE20
    irqReq_r && irqNumber_r == 4'h0 |-> $past(enLow_r[0] && enLow_r[GATE_BIT]))
    else $error("disabled pin zero granted");

  preempt_c: cover property (loActive_r && irqReq_r && irqHigh_r);
  return_from_irq_resume_c: cover property (returnFromIrq ##1 instrDone ##[1:4] irqReq_r);
  both_level_c: cover property (hiFound && loFound && !hiActive_r);
  gate_block_c: cover property (!enLow_r[GATE_BIT] && (|(srcVec & enVec)));

endmodule // interrupt_enable_priority

// file: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
  import irq_pkg::*;
#(
  parameter int W = SYNC_W
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      out_r <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          out_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign pinOut = out_r;
endmodule // pin_sync

// file: sim/core_model.sv
`timescale 1ns/1ps
module core_model (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       irqReq_r,
  input  wire logic [3:0] irqNumber_r,
  input  wire logic       ackOn,
  input  wire logic       doRet,
  input  wire logic       doInstr,
  output logic            irqAck,
  output logic            returnFromIrq,
  output logic            instrDone,
  output logic      [3:0] takenNum
);
  // acks only an offered request, never two edges running
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irqAck   <= 1'b0;
      takenNum <= 4'h0;
    end else begin
      irqAck <= ackOn & irqReq_r & ~irqAck;
      if (ackOn & irqReq_r & ~irqAck) begin
        takenNum <= irqNumber_r;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      returnFromIrq <= 1'b0;
      instrDone     <= 1'b0;
    end else begin
      returnFromIrq <= doRet;
      instrDone     <= doInstr;
    end
  end
endmodule // core_model

// file: sim/tb_interrupt_enable_priority.sv
`timescale 1ns/1ps
module tb_interrupt_enable_priority;
  import irq_pkg::*;
  logic        mclk;
  logic        rstn = 1'b0;
  logic [7:0]  sfrAddr = 8'h00;
  logic        sfrWrEn = 1'b0;
  logic [7:0]  sfrWrData = 8'h00;
  logic        sfrRdEn = 1'b0;
  logic [14:0] src = 15'h0000;
  logic        extOneInvert = 1'b0;
  logic        ackOn = 1'b0;
  logic        doRet = 1'b0;
  logic        doInstr = 1'b0;
  logic        spi = 1'b0;
  logic        fastSer = 1'b0;
  logic [3:0]  padEn = 4'hF;
  logic [3:0]  padLv = 4'hA;
  logic [7:0]  sfrRdData_r;
  logic        irqAck;
  logic        returnFromIrq;
  logic        instrDone;
  logic        irqReq_r;
  logic        irqHigh_r;
  logic [3:0]  irqNumber_r;
  logic [3:0]  takenNum;
  logic [15:0] irqVector_r;
  logic [7:0]  rdv;
  logic        seen;
  int          fail_count = 0;
  int          n_compared = 0;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; $display("FAIL t=%0t got %0h exp %0h", $time, (a), (b)); end end
  interrupt_enable_priority dut (
    .mclk(mclk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
    .sfrRdData_r(sfrRdData_r), .extPinIrqZero(src[0]), .extPinIrqOne(src[2]), .extOneInvert(extOneInvert),
    .firstTimerIrq(src[1]), .secondTimerIrq(src[3]), .thirdTimerIrq(src[5]), .debugSerialIrq(src[4]),
    .wiredSecureIrq(src[6]), .contactlessReqZero(src[10]), .contactlessReqOne(src[9]), .i2cIrq(src[11]),
    .fifoIrq(src[12]), .spiIrq(spi), .fastSerialIrq(fastSer), .usbIrq(src[13]),
    .padIrqPins(src[14] ? 4'hA : 4'h5), .padEnable(padEn), .padLevel(padLv), .irqAck(irqAck),
    .returnFromIrq(returnFromIrq), .instrDone(instrDone), .irqReq_r(irqReq_r), .irqHigh_r(irqHigh_r),
    .irqNumber_r(irqNumber_r), .irqVector_r(irqVector_r));
  core_model core (
    .mclk(mclk), .rstn(rstn), .irqReq_r(irqReq_r), .irqNumber_r(irqNumber_r), .ackOn(ackOn), .doRet(doRet),
    .doInstr(doInstr), .irqAck(irqAck), .returnFromIrq(returnFromIrq), .instrDone(instrDone), .takenNum(takenNum));
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    @(negedge mclk);
    sfrWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    sfrAddr = a;
    sfrRdEn = 1'b1;
    @(negedge mclk);
    sfrRdEn = 1'b0;
    rdv = sfrRdData_r;
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask
  // pins need four edges of sync, so allow a dozen
  task automatic wait_req();
    int k;
    k = 0;
    while (irqReq_r !== 1'b1) begin
      @(negedge mclk);
      k++;
      if (k > 12) begin
        fail_count++;
        $display("FAIL t=%0t got %0h exp %0h", $time, irqReq_r, 1'b1);
        print_verdict();
      end
    end
  endtask
  task automatic quiet(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(negedge mclk);
      seen = seen | irqReq_r;
    end
  endtask
  task automatic t_regs();
    logic [7:0] adr [4];
    logic [7:0] msk [4];
    adr = '{SFR_EN_LOW, SFR_PRIO_LOW, SFR_EN_HIGH, SFR_PRIO_HIGH};
    msk = '{8'hFF, PRIO_LOW_MASK, EN_HIGH_MASK, PRIO_HIGH_MASK};
    for (int i = 0; i < 4; i++) begin
      rd(adr[i]);
      `CHK(rdv, 8'h00)
      wr(adr[i], 8'hFF);
      rd(adr[i]);
      `CHK(rdv, msk[i])
      wr(adr[i], 8'h00);
    end
    wr(8'h90, 8'hFF);
    rd(8'h90);
    `CHK(rdv, 8'h00)
    $display("test regs done");
  endtask
  task automatic t_src();
    logic [7:0] lo;
    logic [7:0] hi;
    for (int n = 0; n < NUM_SRC; n++) begin
      if (n == N_RSV7 || n == N_RSV8) continue;
      lo = (n < 7) ? (8'h01 << n) : 8'h00;
      hi = (n > 8) ? (8'h01 << (n - 7)) : 8'h00;
      src = 15'h0001 << n;
      wr(SFR_EN_LOW, 8'h80);
      quiet(6);
      `CHK(seen, 1'b0)
      wr(SFR_EN_LOW, lo | 8'h80);
      wr(SFR_EN_HIGH, hi);
      wait_req();
      `CHK(irqNumber_r, 4'(n))
      `CHK(irqVector_r, 16'h0003 + 16'(n * 8))
      `CHK(irqHigh_r, 1'b0)
      wr(SFR_EN_LOW, lo);
      quiet(3);
      `CHK(seen, 1'b0)
      src = 15'h0000;
      wr(SFR_EN_HIGH, 8'h00);
    end
    extOneInvert = 1'b1;
    wr(SFR_EN_LOW, 8'h84);
    wait_req();
    `CHK(irqNumber_r, 4'h2)
    extOneInvert = 1'b0;
    spi = 1'b1;
    wr(SFR_EN_LOW, 8'h80);
    wr(SFR_EN_HIGH, 8'h20);
    wait_req();
    `CHK(irqNumber_r, 4'hC)
    spi = 1'b0;
    quiet(3);
    `CHK(seen, 1'b0)
    fastSer = 1'b1;
    wait_req();
    `CHK(irqNumber_r, 4'hC)
    fastSer = 1'b0;
    padEn = 4'h1;
    padLv = 4'h5;
    wr(SFR_EN_HIGH, 8'h80);
    wait_req();
    `CHK(irqNumber_r, 4'hE)
    padEn = 4'h0;
    quiet(3);
    `CHK(seen, 1'b0)
    padEn = 4'h1;
    padLv = 4'h4;
    quiet(3);
    `CHK(seen, 1'b0)
    padEn = 4'hF;
    padLv = 4'hA;
    wr(SFR_EN_HIGH, 8'h00);
    wr(SFR_EN_LOW, 8'h00);
    $display("test sources done");
  endtask
  task automatic t_prio(input logic [14:0] s, input logic [7:0] pl, input logic [7:0] ph,
                        input logic [3:0] en, input logic eh);
    src = s;
    wr(SFR_PRIO_LOW, pl);
    wr(SFR_PRIO_HIGH, ph);
    // sync depth plus the registered offer, so the winner has settled
    repeat (6) @(negedge mclk);
    `CHK(irqNumber_r, en)
    `CHK(irqHigh_r, eh)
    $display("test priority done");
  endtask
  task automatic t_pre();
    src = 15'h0008;
    // let the synchronised pin zero from the last scenario drain first
    repeat (6) @(negedge mclk);
    wait_req();
    pulse(ackOn);
    `CHK(takenNum, 4'h3)
    src = 15'h000A;
    quiet(4);
    `CHK(seen, 1'b0)
    wr(SFR_PRIO_LOW, 8'h02);
    wait_req();
    `CHK(irqNumber_r, 4'h1)
    pulse(ackOn);
    quiet(4);
    `CHK(seen, 1'b0)
    pulse(doRet);
    quiet(4);
    `CHK(seen, 1'b0)
    pulse(doInstr);
    wait_req();
    `CHK(irqNumber_r, 4'h1)
    src = 15'h0000;
    pulse(doRet);
    pulse(doInstr);
    $display("test preempt done");
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    t_regs();
    t_src();
    wr(SFR_EN_LOW, 8'hFF);
    wr(SFR_EN_HIGH, 8'hFC);
    t_prio(15'h000A, 8'h00, 8'h00, 4'h1, 1'b0);
    t_prio(15'h000A, 8'h08, 8'h00, 4'h3, 1'b1);
    t_prio(15'h0060, 8'h40, 8'h00, 4'h6, 1'b1);
    t_prio(15'h6000, 8'h00, 8'h80, 4'hE, 1'b1);
    t_prio(15'h0801, 8'h00, 8'h10, 4'hB, 1'b1);
    wr(SFR_PRIO_HIGH, 8'h00);
    wr(SFR_PRIO_LOW, 8'h00);
    t_pre();
    print_verdict();
  end
endmodule // tb_interrupt_enable_priority
